// ==== design/irj_exec.sv ====
// Execution unit for interrupt return, fast interrupt entry and absolute jumps.
`timescale 1ns/100ps
module irj_exec
#(
	parameter bit EXT_STACK = 1'b0
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_exec,
	input wire logic [7:0] i_opcode,
	input wire logic [7:0] i_operand1,
	input wire logic [7:0] i_operand2,
	input wire logic i_fast_irq,
	input wire logic i_ip_load,
	input wire logic [15:0] i_ip_value,
	input wire logic i_sp_load,
	input wire logic [15:0] i_sp_value,
	input wire logic i_gie_load,
	input wire logic i_gie_value,
	input wire logic [7:0] i_rd_data,
	output logic o_rd_en,
	output logic o_rd_reg,
	output logic [15:0] o_rd_addr,
	output logic [15:0] o_pc,
	output logic [15:0] o_sp,
	output logic [15:0] o_ip,
	output logic [7:0] o_flags,
	output logic o_gie,
	output logic o_busy,
	output logic o_done
);
	import irj_pkg::*;

	exec_state_t state_q;
	logic [3:0] stp_q;
	logic [3:0] last_q;
	logic taken_q;
	logic [7:0] op1_q;
	logic [7:0] op2_q;
	logic [15:0] tgt_q;
	logic [15:0] pc_q;
	logic [15:0] sp_q;
	logic [15:0] ip_q;
	logic [7:0] flags_q;
	logic [7:0] shadow_q;
	logic gie_q;
	logic busy_q;
	logic done_q;
	logic rd_en_q;
	logic rd_reg_q;
	logic [15:0] rd_addr_q;
	logic is_interrupt_return_instr;
	logic is_jda;
	logic is_jirr;
	logic cond_ok;
	logic idle;
	logic start;
	logic fin;
	logic irq_take;
	logic [3:0] nrm_cyc;

	cond_eval u_cond
	(
		.i_code(i_opcode[7:4]), // RL10
		.i_flags(flags_q),
		.o_true(cond_ok)
	);

	assign is_interrupt_return_instr = (i_opcode == OPC_INTERRUPT_RETURN_INSTR); // RL6
	assign is_jda = (i_opcode[3:0] == NIB_JP_DA); // RL9 RL10
	assign is_jirr = (i_opcode == OPC_JP_IRR); // RL11
	assign idle = (state_q == ST_IDLE);
	assign start = idle && i_exec && (is_interrupt_return_instr || is_jda || is_jirr);
	assign fin = busy_q && (stp_q == last_q);
	// A new instruction wins over the interrupt; the request is a level and is taken next time.
	assign irq_take = idle && !i_exec && i_fast_irq && gie_q && !flags_q[FL_FIS];
	assign nrm_cyc = EXT_STACK ? CYC_INTERRUPT_RETURN_INSTR_EXT : CYC_INTERRUPT_RETURN_INSTR_INT; // RL6

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q <= ST_IDLE;
			stp_q <= 4'h0;
			last_q <= 4'h0;
			taken_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (start)
		begin
			busy_q <= 1'b1;
			done_q <= 1'b0;
			stp_q <= 4'h0;
			taken_q <= cond_ok;
			if (is_interrupt_return_instr && flags_q[FL_FIS])
			begin
				state_q <= ST_INTERRUPT_RETURN_INSTR_FAST; // RL4
				last_q <= CYC_INTERRUPT_RETURN_INSTR_FAST - STEP_ONE; // RL6
			end
			else if (is_interrupt_return_instr)
			begin
				state_q <= ST_INTERRUPT_RETURN_INSTR_NRM; // RL3
				last_q <= nrm_cyc - STEP_ONE; // RL6
			end
			else if (is_jirr)
			begin
				state_q <= ST_JP_IRR;
				last_q <= CYC_JP_IRR - STEP_ONE; // RL11
			end
			else
			begin
				state_q <= ST_JP_DA;
				last_q <= cond_ok ? CYC_JP_TAKEN - STEP_ONE : CYC_JP_SKIP - STEP_ONE; // RL9
			end
		end
		else if (fin)
		begin
			state_q <= ST_IDLE;
			busy_q <= 1'b0;
			done_q <= 1'b1;
		end
		else
		begin
			done_q <= 1'b0;
			if (busy_q)
				stp_q <= stp_q + STEP_ONE;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			op1_q <= 8'h00;
			op2_q <= 8'h00;
		end
		else if (start)
		begin
			op1_q <= i_operand1;
			op2_q <= i_operand2;
		end
	end

	// Read port: data is expected on i_rd_data one cycle after o_rd_en is seen high.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rd_en_q <= 1'b0;
			rd_reg_q <= 1'b0;
			rd_addr_q <= 16'h0000;
		end
		else
		begin
			rd_en_q <= 1'b0;
			case (state_q)
				ST_INTERRUPT_RETURN_INSTR_NRM:
				begin
					if (stp_q <= STP_RD2)
					begin
						rd_en_q <= 1'b1; // RL1
						rd_reg_q <= 1'b0;
						rd_addr_q <= sp_q + {12'h000, stp_q}; // RL1
					end
				end
				ST_JP_IRR:
				begin
					if (stp_q <= STP_RD1)
					begin
						rd_en_q <= 1'b1;
						rd_reg_q <= 1'b1;
						rd_addr_q <= {REG_PAGE, op1_q + ((stp_q == STP_RD1) ? PAIR_LO_STEP : 8'h00)}; // RL11
					end
				end
				default: rd_en_q <= 1'b0;
			endcase
		end
	end

	// High byte of the popped or fetched address arrives first, low byte second.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			tgt_q <= 16'h0000;
		else if ((state_q == ST_INTERRUPT_RETURN_INSTR_NRM && stp_q == STP_CAP1) ||
			(state_q == ST_JP_IRR && stp_q == STP_CAP0))
			tgt_q[15:8] <= i_rd_data; // RL1 RL11
		else if ((state_q == ST_INTERRUPT_RETURN_INSTR_NRM && stp_q == STP_CAP2) ||
			(state_q == ST_JP_IRR && stp_q == STP_CAP1))
			tgt_q[7:0] <= i_rd_data; // RL1 RL11
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pc_q <= PC_RST;
			ip_q <= IP_RST;
		end
		else if (irq_take)
		begin
			pc_q <= ip_q; // RL5
			ip_q <= pc_q; // RL5
		end
		else if (fin)
		begin
			case (state_q)
				ST_INTERRUPT_RETURN_INSTR_NRM: pc_q <= tgt_q; // RL1
				ST_INTERRUPT_RETURN_INSTR_FAST:
				begin
					pc_q <= ip_q; // RL4
					ip_q <= pc_q + LEN_INTERRUPT_RETURN_INSTR; // RL4
				end
				ST_JP_DA: pc_q <= taken_q ? {op1_q, op2_q} : pc_q + LEN_JP_DA; // RL8
				ST_JP_IRR: pc_q <= tgt_q; // RL11
				default: pc_q <= pc_q;
			endcase
		end
		else if (idle && i_ip_load)
			ip_q <= i_ip_value;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			sp_q <= SP_RST;
		else if (fin && state_q == ST_INTERRUPT_RETURN_INSTR_NRM)
			sp_q <= sp_q + SP_POP_TOTAL; // RL1
		else if (idle && i_sp_load)
			sp_q <= i_sp_value;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			flags_q <= FLAGS_RST;
			shadow_q <= FLAGS_RST;
		end
		else if (irq_take)
		begin
			shadow_q <= flags_q;
			flags_q <= flags_q | FIS_MASK; // RL5
		end
		else if (state_q == ST_INTERRUPT_RETURN_INSTR_NRM && stp_q == STP_CAP0)
			flags_q <= i_rd_data; // RL1
		else if (fin && state_q == ST_INTERRUPT_RETURN_INSTR_FAST)
			flags_q <= shadow_q & ~FIS_MASK; // RL4
	end

	// Entry drops the enable so a held request cannot re-enter before the return.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			gie_q <= 1'b0;
		else if (irq_take)
			gie_q <= 1'b0;
		else if (fin && (state_q == ST_INTERRUPT_RETURN_INSTR_NRM || state_q == ST_INTERRUPT_RETURN_INSTR_FAST))
			gie_q <= 1'b1; // RL2
		else if (idle && i_gie_load)
			gie_q <= i_gie_value;
	end

	assign o_rd_en = rd_en_q;
	assign o_rd_reg = rd_reg_q;
	assign o_rd_addr = rd_addr_q;
	assign o_pc = pc_q;
	assign o_sp = sp_q;
	assign o_ip = ip_q;
	assign o_flags = flags_q;
	assign o_gie = gie_q;
	assign o_busy = busy_q;
	assign o_done = done_q;

	// Outputs change on the edge that ends an instruction, so a property sampling on the next
	// edge sees them one cycle after the documented count; every length below allows for that.
	localparam int LEN_NRM = EXT_STACK ? int'(CYC_INTERRUPT_RETURN_INSTR_EXT) : int'(CYC_INTERRUPT_RETURN_INSTR_INT);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_nrm_start;
		start && is_interrupt_return_instr && !flags_q[FL_FIS];
	endsequence

	sequence s_fast_start;
		start && is_interrupt_return_instr && flags_q[FL_FIS];
	endsequence

	property p_nrm_len;
		s_nrm_start |=> ##LEN_NRM o_done;
	endproperty
	a_nrm_len: assert property (p_nrm_len) else $error("normal return length wrong"); // RL6

	property p_fast_len;
		s_fast_start |=> !o_done [*6] ##1 o_done;
	endproperty
	a_fast_len: assert property (p_fast_len) else $error("fast return length wrong"); // RL6

	property p_nrm_sp;
		s_nrm_start |=> ##LEN_NRM (o_sp == $past(o_sp) + SP_POP_TOTAL) && o_gie;
	endproperty
	a_nrm_sp: assert property (p_nrm_sp) else $error("stack pointer or enable wrong"); // RL1

	property p_interrupt_return_instr_gie;
		start && is_interrupt_return_instr |-> ##[7:13] (o_done && o_gie);
	endproperty
	a_interrupt_return_instr_gie: assert property (p_interrupt_return_instr_gie) else $error("enable not set by return"); // RL2

	property p_fast_ret;
		s_fast_start |-> ##7 (!o_flags[FL_FIS] && o_pc == $past(o_ip) && o_sp == $past(o_sp));
	endproperty
	a_fast_ret: assert property (p_fast_ret) else $error("fast return restore wrong"); // RL4

	property p_nrm_gate;
		start && is_interrupt_return_instr |=> (state_q == ST_INTERRUPT_RETURN_INSTR_NRM) != $past(flags_q[FL_FIS]);
	endproperty
	a_nrm_gate: assert property (p_nrm_gate) else $error("stack return taken with status set"); // RL3

	property p_entry;
		irq_take |=> o_flags[FL_FIS] && o_pc == $past(o_ip) && o_ip == $past(o_pc) && !o_gie;
	endproperty
	a_entry: assert property (p_entry) else $error("fast entry swap wrong"); // RL5

	property p_jp_skip;
		start && is_jda && !cond_ok |-> ##7 (o_done && o_pc == $past(o_pc) + LEN_JP_DA);
	endproperty
	a_jp_skip: assert property (p_jp_skip) else $error("untaken jump wrong"); // RL8

	property p_jp_take;
		start && is_jda && cond_ok |-> ##9 (o_done && o_pc == {$past(i_operand1, 9), $past(i_operand2, 9)});
	endproperty
	a_jp_take: assert property (p_jp_take) else $error("taken jump wrong"); // RL9

	property p_jirr;
		start && is_jirr |=> !o_done [*8] ##1 o_done;
	endproperty
	a_jirr: assert property (p_jirr) else $error("register pair jump length wrong"); // RL11

	property p_always;
		start && is_jda && i_opcode[7:4] == 4'h8 |=> taken_q;
	endproperty
	a_always: assert property (p_always) else $error("always condition not taken"); // RL12
endmodule

// ==== include/irj_pkg.sv ====
// Package of opcodes, flag layout, cycle counts and reset values for the return and jump unit.
// Behaviour
// RL1: Normal return pops flags at SP, then the program counter, SP ends three higher.
// RL2: Every interrupt return sets the global interrupt enable bit to one.
// RL3: Stack-based return only when fast-interrupt status bit one of flags is zero.
// RL4: Fast return swaps program counter and pointer, restores shadow flags, clears status; the code loads the pointer with the program counter plus one.
// RL5: Fast interrupt entry sets status bit and swaps program counter with pointer.
// RL6: Return opcode BF; normal takes 10 or 12 cycles, fast takes 6.
// RL7: Software must not clear pending status right before the return instruction.
// RL8: Conditional jump loads target only when the condition holds, else falls through.
// RL9: Conditional jump is three bytes, low nibble D, 8 cycles taken, 6 not.
// RL10: First byte of conditional jump splits into condition and operation nibbles.
// RL11: Opcode 30, two bytes, 8 cycles, loads PC from the addressed register pair.
// RL12: Each of sixteen condition codes is evaluated against carry, zero, sign, overflow.
package irj_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_INTERRUPT_RETURN_INSTR_NRM,
		ST_INTERRUPT_RETURN_INSTR_FAST,
		ST_JP_DA,
		ST_JP_IRR
	} exec_state_t;

	localparam logic [7:0] OPC_INTERRUPT_RETURN_INSTR = 8'hBF;
	localparam logic [7:0] OPC_JP_IRR = 8'h30;
	localparam logic [3:0] NIB_JP_DA = 4'hD;

	localparam logic [15:0] LEN_INTERRUPT_RETURN_INSTR = 16'h0001;
	localparam logic [15:0] LEN_JP_DA = 16'h0003;
	localparam logic [15:0] SP_POP_TOTAL = 16'h0003;
	localparam logic [15:0] SP_POP_PC_HI = 16'h0001;
	localparam logic [15:0] SP_POP_PC_LO = 16'h0002;
	localparam logic [7:0] PAIR_LO_STEP = 8'h01;

	localparam logic [3:0] CYC_INTERRUPT_RETURN_INSTR_INT = 4'hA;
	localparam logic [3:0] CYC_INTERRUPT_RETURN_INSTR_EXT = 4'hC;
	localparam logic [3:0] CYC_INTERRUPT_RETURN_INSTR_FAST = 4'h6;
	localparam logic [3:0] CYC_JP_TAKEN = 4'h8;
	localparam logic [3:0] CYC_JP_SKIP = 4'h6;
	localparam logic [3:0] CYC_JP_IRR = 4'h8;
	localparam logic [3:0] STEP_ONE = 4'h1;

	// Read issue and data capture steps inside a multi-cycle sequence.
	localparam logic [3:0] STP_RD0 = 4'h0;
	localparam logic [3:0] STP_RD1 = 4'h1;
	localparam logic [3:0] STP_RD2 = 4'h2;
	localparam logic [3:0] STP_CAP0 = 4'h2;
	localparam logic [3:0] STP_CAP1 = 4'h3;
	localparam logic [3:0] STP_CAP2 = 4'h4;

	localparam logic [7:0] FLAGS_REG_ADDR = 8'hD5;
	localparam int FL_C = 7;
	localparam int FL_Z = 6;
	localparam int FL_S = 5;
	localparam int FL_V = 4;
	localparam int FL_FIS = 1;
	localparam logic [7:0] FIS_MASK = 8'h02;

	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] SP_RST = 16'h0000;
	localparam logic [15:0] IP_RST = 16'h0000;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] REG_PAGE = 8'h00;

endpackage

// ==== design/cond_eval.sv ====
// Condition-code evaluator for the four-bit condition field of a conditional jump.
`timescale 1ns/100ps
module cond_eval
(
	input wire logic [3:0] i_code,
	input wire logic [7:0] i_flags,
	output logic o_true
);
	import irj_pkg::*;

	logic c;
	logic z;
	logic s;
	logic v;
	logic base;

	assign c = i_flags[FL_C];
	assign z = i_flags[FL_Z];
	assign s = i_flags[FL_S];
	assign v = i_flags[FL_V];

	// The upper half of the table is the negation of the lower half, so only eight are decoded.
	always_comb
	begin
		case (i_code[2:0]) // RL12
			3'h0: base = 1'b0;
			3'h1: base = s ^ v;
			3'h2: base = z | (s ^ v);
			3'h3: base = c | z;
			3'h4: base = v;
			3'h5: base = s;
			3'h6: base = z;
			3'h7: base = c;
			default: base = 1'b0;
		endcase
		o_true = base ^ i_code[3]; // RL12
	end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the interrupt return and absolute jump execution unit.
`timescale 1ns/100ps
module testbench;
	import irj_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_exec = 1'b0;
	logic [7:0] i_opcode = 8'h00;
	logic [7:0] i_operand1 = 8'h00;
	logic [7:0] i_operand2 = 8'h00;
	logic i_fast_irq = 1'b0;
	logic i_ip_load = 1'b0;
	logic [15:0] i_ip_value = 16'h0000;
	logic i_sp_load = 1'b0;
	logic [15:0] i_sp_value = 16'h0000;
	logic i_gie_load = 1'b0;
	logic i_gie_value = 1'b0;
	logic [7:0] i_rd_data = 8'h00;
	logic o_rd_en, o_rd_reg, o_gie, o_busy, o_done;
	logic [15:0] o_rd_addr, o_pc, o_sp, o_ip;
	logic [7:0] o_flags;
	logic [7:0] mem [256];
	logic [16:0] rdq [$];
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [15:0] epc;

	irj_exec #(.EXT_STACK(1'b0)) i_irj_exec (.i_clk(i_clk), .i_rst(i_rst), .i_exec(i_exec),
		.i_opcode(i_opcode), .i_operand1(i_operand1), .i_operand2(i_operand2),
		.i_fast_irq(i_fast_irq), .i_ip_load(i_ip_load), .i_ip_value(i_ip_value),
		.i_sp_load(i_sp_load), .i_sp_value(i_sp_value), .i_gie_load(i_gie_load),
		.i_gie_value(i_gie_value), .i_rd_data(i_rd_data), .o_rd_en(o_rd_en),
		.o_rd_reg(o_rd_reg), .o_rd_addr(o_rd_addr), .o_pc(o_pc), .o_sp(o_sp), .o_ip(o_ip),
		.o_flags(o_flags), .o_gie(o_gie), .o_busy(o_busy), .o_done(o_done));

	initial
	begin
		forever #4 i_clk = ~i_clk;
	end

	// Read data follows each strobe by one cycle; otherwise the bus toggles so stale data shows.
	always @(posedge i_clk)
	begin
		if (o_rd_en === 1'b1)
		begin
			rdq.push_back({o_rd_reg, o_rd_addr});
			i_rd_data <= #1 mem[o_rd_addr[7:0]];
		end
		else
			i_rd_data <= #1 ~i_rd_data;
	end

	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick();
		@(posedge i_clk);
		#1;
	endtask

	task automatic run(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2,
		input int exp_n);
		int n;
		n = 0;
		tick();
		i_opcode = op;
		i_operand1 = o1;
		i_operand2 = o2;
		i_exec = 1'b1;
		tick();
		i_exec = 1'b0;
		check(o_busy, 1'b1);
		while (o_done !== 1'b1 && n < 30)
		begin
			tick();
			n++;
		end
		check(17'(n), 17'(exp_n));
	endtask

	// Stack-based return with the given flag byte and return address.
	task automatic nret(input logic [15:0] sp, input logic [7:0] fl, input logic [15:0] ra);
		tick();
		i_sp_load = 1'b1;
		i_sp_value = sp;
		i_gie_load = 1'b1;
		i_gie_value = 1'b0;
		mem[sp[7:0]] = fl;
		mem[sp[7:0] + 8'h01] = ra[15:8];
		mem[sp[7:0] + 8'h02] = ra[7:0];
		rdq.delete();
		tick();
		i_sp_load = 1'b0;
		i_gie_load = 1'b0;
		run(OPC_INTERRUPT_RETURN_INSTR, 8'h00, 8'h00, 10);
		check(o_pc, ra);
		check(o_sp, sp + 16'h0003);
		check(o_flags, fl);
		check(o_gie, 1'b1);
		check(17'(rdq.size()), 17'h00003);
		for (int k = 0; k < 3 && k < rdq.size(); k++)
			check(rdq[k], {1'b0, sp + 16'(k)});
		epc = ra;
		$display("normal return done");
	endtask

	task automatic fast_path();
		nret(16'h0040, 8'h80, 16'h1234);
		i_ip_load = 1'b1;
		i_ip_value = 16'h0100;
		i_gie_load = 1'b1;
		i_gie_value = 1'b1;
		tick();
		i_ip_load = 1'b0;
		i_gie_load = 1'b0;
		i_fast_irq = 1'b1;
		tick();
		i_fast_irq = 1'b0;
		check(o_pc, 16'h0100);
		check(o_gie, 1'b0);
		check(o_ip, 16'h1234);
		check(o_flags, 8'h82);
		run(OPC_INTERRUPT_RETURN_INSTR, 8'h00, 8'h00, 6);
		check(o_pc, 16'h1234);
		check(o_ip, 16'h0101);
		check(o_flags, 8'h80);
		check(o_gie, 1'b1);
		$display("fast interrupt done");
	endtask

	function automatic logic cond_ok(input logic [3:0] c, input logic [7:0] f);
		logic b;
		case (c[2:0])
			3'h0: b = 1'b0;
			3'h1: b = f[5] ^ f[4];
			3'h2: b = f[6] | (f[5] ^ f[4]);
			3'h3: b = f[7] | f[6];
			3'h4: b = f[4];
			3'h5: b = f[5];
			3'h6: b = f[6];
			default: b = f[7];
		endcase
		return c[3] ? ~b : b;
	endfunction

	task automatic cond_jumps(input logic [7:0] fl);
		logic t;
		nret(16'h0060, fl, 16'h5000);
		for (int c = 0; c < 16; c++)
		begin
			t = cond_ok(4'(c), fl);
			run({4'(c), 4'hD}, 8'hA5, 8'h5A, t ? 8 : 6);
			epc = t ? 16'hA55A : epc + 16'h0003;
			check(o_pc, epc);
		end
		$display("conditional jumps done");
	endtask

	task automatic pair_jump();
		mem[8'h20] = 8'h01;
		mem[8'h21] = 8'h20;
		rdq.delete();
		run(OPC_JP_IRR, 8'h20, 8'h00, 8);
		check(o_pc, 16'h0120);
		check(17'(rdq.size()), 17'h00002);
		for (int k = 0; k < 2 && k < rdq.size(); k++)
			check(rdq[k], {1'b1, 16'h0020 + 16'(k)});
		tick();
		i_opcode = 8'h00;
		i_exec = 1'b1;
		tick();
		i_exec = 1'b0;
		tick();
		check(o_busy, 1'b0);
		check(o_pc, 16'h0120);
		$display("pair jump and unknown opcode done");
	endtask

	initial
	begin
		for (int k = 0; k < 256; k++)
			mem[k] = 8'h00;
		repeat (5) @(posedge i_clk);
		#1;
		i_rst = 1'b0;
		check({o_pc, o_gie}, 17'h00000);
		check({o_sp, o_busy}, 17'h00000);
		check({o_ip, o_done}, 17'h00000);
		check({o_flags, o_rd_en}, 17'h00000);
		fast_path();
		cond_jumps(8'h80);
		cond_jumps(8'h70);
		cond_jumps(8'h20);
		cond_jumps(8'h40);
		pair_jump();
		test_done();
	end
endmodule
